// file: design/grfbc_pkg.sv
`default_nettype none
package grfbc_pkg;
   // register byte addresses, even byte is the low half of a word
   localparam logic [6:0]  ADDR_FINE       = 7'h08;
   localparam logic [6:0]  ADDR_COARSE     = 7'h0A;
   localparam logic [6:0]  ADDR_PERIOD     = 7'h1E;
   localparam logic [6:0]  ADDR_TAP        = 7'h20;
   localparam logic [6:0]  ADDR_DEC        = 7'h22;
   localparam logic [6:0]  ADDR_CMD        = 7'h28;
   // command word layout
   localparam int          CMD_WR_BIT      = 15;
   localparam int          CMD_ADDR_MSB    = 14;
   localparam int          CMD_ADDR_LSB    = 8;
   localparam int          CMD_NULL_BIT    = 0;
   localparam int          CMD_RESTORE_BIT = 1;
   // reset values
   localparam logic [15:0] PERIOD_RST      = 16'h001F;
   localparam logic [15:0] TAP_RST         = 16'h0000;
   localparam logic [15:0] DEC_RST         = 16'h0000;
   localparam logic [15:0] OFFSET_RST      = 16'h0000;
   // field limits
   localparam logic [15:0] PERIOD_MIN      = 16'h000F;
   localparam logic [2:0]  TAP_EXP_MAX     = 3'h6;
   localparam logic [4:0]  DEC_EXP_MAX     = 5'h10;
   localparam int          TAP_EXP_MSB     = 2;
   localparam int          DEC_EXP_MSB     = 4;
   // timing
   localparam int          CLK_HZ          = 250_000_000;
   localparam int          BASE_RATE_HZ    = 32_768;
   localparam int          BASE_DIV_CYC    = CLK_HZ / BASE_RATE_HZ;
   localparam int          RESTORE_MS      = 72;
   localparam int          RESTORE_CYC     = RESTORE_MS * (CLK_HZ / 1000);
   // filter sequencer and nulling phases
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0, ST_STG1 = 2'h1, ST_STG2 = 2'h3, ST_DEC = 2'h2
   } grfbc_fsm_type;
   typedef enum logic [1:0] {
      NL_OFF = 2'h0, NL_ALIGN = 2'h1, NL_TAKE = 2'h3, NL_STORE = 2'h2
   } grfbc_null_type;
endpackage : grfbc_pkg
`default_nettype wire

// file: design/grfbc_ext_tick.sv
`timescale 1ns/1ps
`default_nettype none
module grfbc_ext_tick (
   // clocks and reset
   input  wire logic clock_i,
   input  wire logic rst_b_i,
   input  wire logic ext_clk_i,
   // one-cycle pulse per rising external edge, on clock_i
   output logic      tick_o
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic seen;
   } grfbc_sync_type;

   logic           ext_tgl_reg;
   grfbc_sync_type s_reg;
   grfbc_sync_type s_next;

   // toggle on every rising external edge
   always_ff @(posedge ext_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ext_tgl_reg <= 1'b0;
      end else begin
         ext_tgl_reg <= ~ext_tgl_reg;
      end
   end

   // two-stage synchroniser and edge memory
   always_comb begin
      s_next       = s_reg;
      s_next.sync1 = ext_tgl_reg;
      s_next.sync2 = s_reg.sync1;
      s_next.seen  = s_reg.sync2;
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick_o = s_reg.sync2 ^ s_reg.seen;
endmodule : grfbc_ext_tick
`default_nettype wire

// file: design/grfbc_tap_mem.sv
`timescale 1ns/1ps
`default_nettype none
module grfbc_tap_mem #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 64
) (
   // clock
   input  wire logic                     clock_i,
   // write port
   input  wire logic                     wr_en_i,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
   input  wire logic [WIDTH-1:0]         wr_data_i,
   // registered read port
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
   output logic      [WIDTH-1:0]         rd_data_o
);
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("tap memory depth must be a power of two");
   end

   logic [WIDTH-1:0] mem_reg [DEPTH];

   // read before write on the same address
   always_ff @(posedge clock_i) begin
      if (wr_en_i) begin
         mem_reg[wr_addr_i] <= wr_data_i;
      end
      rd_data_o <= mem_reg[rd_addr_i];
   end
endmodule : grfbc_tap_mem
`default_nettype wire

// file: design/grfbc_top.sv
// Summary of operation
// - internal sample rate is 32768/(period code+1), never above 2048 SPS
// - sample period code resets to 0x001F, that is 1024 SPS
// - period code zero stops internal clock, external pin clocks samples
// - two cascaded 2^B-tap averagers, B from tap bits [2:0], max 6
// - final stage averages and decimates by 2^D, D from bits [4:0], max 16
// - command bit 0 starts nulling after one full output data cycle
// - nulling negates the filtered rate before offsets into offsets, then updates memory
// - register port ignores every transaction while nulling runs
// - nulling cannot be aborted except by power or hardware reset
// - coarse offset, two's complement, is summed into the primary output
// - 16-bit fine offset is summed in, formatted like secondary output
// - command bit 1 clears offsets and data, updates memory within 72 ms
// - tap and decimation exponents reset to zero
// - command bits self-clear when their function completes
// - period, tap and decimation registers sit at 0x1E, 0x20, 0x22
`timescale 1ns/1ps
`default_nettype none
module grfbc_top #(
   parameter int BASE_DIV    = grfbc_pkg::BASE_DIV_CYC,
   parameter int RESTORE_CYC = grfbc_pkg::RESTORE_CYC
) (
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   // external sample clock pin
   input  wire logic        external_clock_input_pin_i,
   // register command port
   input  wire logic        cmd_valid_i,
   input  wire logic [15:0] cmd_word_i,
   output logic      [15:0] rd_data_o,
   output logic             rd_valid_o,
   // sensor input and rate outputs
   input  wire logic [31:0] raw_rate_i,
   output logic      [15:0] primary_rate_output_o,
   output logic      [15:0] secondary_rate_output_o,
   output logic             data_ready_o,
   // non-volatile memory handshake
   output logic             nvm_update_o,
   input  wire logic        nvm_done_i
);
   localparam int DEPTH = 1 << grfbc_pkg::TAP_EXP_MAX;
   localparam int AW    = $clog2(DEPTH);
   localparam int SUM_W = 32 + AW + 1;
   localparam int ACC_W = 32 + 17;
   localparam int DIV_W = $clog2(BASE_DIV + 1);
   localparam int NVM_W = $clog2(RESTORE_CYC + 1);

   if (BASE_DIV < 2 || RESTORE_CYC < 1) begin : g_bad_param
      $error("base divider must be at least 2 and restore count at least 1");
   end

   typedef struct packed {
      logic [15:0]                period;
      logic [15:0]                tap_exp;
      logic [15:0]                dec_exp;
      logic [15:0]                coarse;
      logic [15:0]                fine;
      logic                       cmd_null;
      logic                       cmd_restore;
      logic [2:0]                 act_b;
      logic [4:0]                 act_d;
      logic [DIV_W-1:0]           base_cnt;
      logic [15:0]                per_cnt;
      grfbc_pkg::grfbc_fsm_type   fsm;
      grfbc_pkg::grfbc_null_type  null_ph;
      logic [31:0]                sample;
      logic [AW-1:0]              wp;
      logic [AW:0]                fill1;
      logic [AW:0]                fill2;
      logic [SUM_W-1:0]           sum1;
      logic [SUM_W-1:0]           sum2;
      logic [31:0]                avg1;
      logic [16:0]                dec_cnt;
      logic [ACC_W-1:0]           acc;
      logic [NVM_W-1:0]           nvm_cnt;
      logic [15:0]                rd_data;
      logic                       rd_valid;
      logic [31:0]                rate;
      logic                       ready;
      logic                       nvm_upd;
   } grfbc_state_type;

   grfbc_state_type   s_reg;
   grfbc_state_type   s_next;
   logic              ext_tick;
   logic              int_tick;
   logic              tick;
   logic              out_evt;
   logic              restore_go;
   logic [31:0]       unc;
   logic [15:0]       code_eff;
   logic [2:0]        b_new;
   logic [4:0]        d_new;
   logic [6:0]        cmd_addr;
   logic [7:0]        cmd_data;
   logic [AW-1:0]     mem_rd_addr;
   logic              wr1;
   logic              wr2;
   logic [31:0]       rd1;
   logic [31:0]       rd2;
   logic [AW:0]       taps;
   logic signed [SUM_W-1:0] old_v;
   logic signed [SUM_W-1:0] sum_v;
   logic signed [ACC_W-1:0] acc_v;

   // replace one byte of a 16-bit register
   function automatic logic [15:0] put_byte(logic [15:0] w, logic hi, logic [7:0] d);
      return hi ? {d, w[7:0]} : {w[15:8], d};
   endfunction : put_byte

   // byte address falls inside the word at base
   function automatic logic is_word(logic [6:0] a, logic [6:0] base);
      return a[6:1] == base[6:1];
   endfunction : is_word

   // external clock pin crosses into clock_i as a pulse
   grfbc_ext_tick u_ext (
      .clock_i   (clock_i),
      .rst_b_i   (rst_b_i),
      .ext_clk_i (external_clock_input_pin_i),
      .tick_o    (ext_tick)
   );

   // tap history for both averaging stages
   grfbc_tap_mem #(.WIDTH(32), .DEPTH(DEPTH)) u_mem1 (
      .clock_i   (clock_i),
      .wr_en_i   (wr1),
      .wr_addr_i (s_reg.wp),
      .wr_data_i (s_reg.sample),
      .rd_addr_i (mem_rd_addr),
      .rd_data_o (rd1)
   );
   grfbc_tap_mem #(.WIDTH(32), .DEPTH(DEPTH)) u_mem2 (
      .clock_i   (clock_i),
      .wr_en_i   (wr2),
      .wr_addr_i (s_reg.wp),
      .wr_data_i (s_reg.avg1),
      .rd_addr_i (mem_rd_addr),
      .rd_data_o (rd2)
   );

   // next-state logic
   always_comb begin
      s_next          = s_reg;
      s_next.rd_valid = 1'b0;
      s_next.ready    = 1'b0;
      s_next.nvm_upd  = 1'b0;
      int_tick        = 1'b0;
      out_evt         = 1'b0;
      restore_go      = 1'b0;
      unc             = 32'h0000_0000;
      wr1             = 1'b0;
      wr2             = 1'b0;
      old_v           = '0;
      sum_v           = '0;
      acc_v           = '0;
      cmd_addr        = cmd_word_i[grfbc_pkg::CMD_ADDR_MSB:grfbc_pkg::CMD_ADDR_LSB];
      cmd_data        = cmd_word_i[7:0];
      taps            = (AW + 1)'(1) << s_reg.act_b;
      mem_rd_addr     = s_reg.wp - taps[AW-1:0];
      b_new = (s_reg.tap_exp[grfbc_pkg::TAP_EXP_MSB:0] > grfbc_pkg::TAP_EXP_MAX) ?
              grfbc_pkg::TAP_EXP_MAX : s_reg.tap_exp[grfbc_pkg::TAP_EXP_MSB:0];
      d_new = (s_reg.dec_exp[grfbc_pkg::DEC_EXP_MSB:0] > grfbc_pkg::DEC_EXP_MAX) ?
              grfbc_pkg::DEC_EXP_MAX : s_reg.dec_exp[grfbc_pkg::DEC_EXP_MSB:0];
      code_eff = (s_reg.period < grfbc_pkg::PERIOD_MIN) ?
                 grfbc_pkg::PERIOD_MIN : s_reg.period;

      // internal sample clock, held while the period code is zero
      if (s_reg.period != 16'h0000) begin
         if (s_reg.base_cnt == '0) begin
            s_next.base_cnt = DIV_W'(BASE_DIV - 1);
            if (s_reg.per_cnt == 16'h0000) begin
               s_next.per_cnt = code_eff;
               int_tick       = 1'b1;
            end else begin
               s_next.per_cnt = s_reg.per_cnt - 16'h0001;
            end
         end else begin
            s_next.base_cnt = s_reg.base_cnt - DIV_W'(1);
         end
      end
      tick = (s_reg.period == 16'h0000) ? ext_tick : int_tick;

      // register port, mute while nulling
      if (cmd_valid_i && !s_reg.cmd_null) begin
         if (cmd_word_i[grfbc_pkg::CMD_WR_BIT]) begin
            // byte writes, so a word changes in two steps
            if (is_word(cmd_addr, grfbc_pkg::ADDR_PERIOD)) begin
               s_next.period = put_byte(s_reg.period, cmd_addr[0], cmd_data);
            end
            if (is_word(cmd_addr, grfbc_pkg::ADDR_TAP)) begin
               s_next.tap_exp = put_byte(s_reg.tap_exp, cmd_addr[0], cmd_data);
            end
            if (is_word(cmd_addr, grfbc_pkg::ADDR_DEC)) begin
               s_next.dec_exp = put_byte(s_reg.dec_exp, cmd_addr[0], cmd_data);
            end
            if (is_word(cmd_addr, grfbc_pkg::ADDR_COARSE)) begin
               s_next.coarse = put_byte(s_reg.coarse, cmd_addr[0], cmd_data);
            end
            if (is_word(cmd_addr, grfbc_pkg::ADDR_FINE)) begin
               s_next.fine = put_byte(s_reg.fine, cmd_addr[0], cmd_data);
            end
            if (is_word(cmd_addr, grfbc_pkg::ADDR_CMD) && !cmd_addr[0]) begin
               if (cmd_data[grfbc_pkg::CMD_RESTORE_BIT]) begin
                  restore_go = 1'b1;
               end else if (cmd_data[grfbc_pkg::CMD_NULL_BIT]) begin
                  s_next.cmd_null = 1'b1;
                  s_next.null_ph  = grfbc_pkg::NL_ALIGN;
               end
            end
         end else begin
            s_next.rd_valid = 1'b1;
            case ({cmd_addr[6:1], 1'b0})
               grfbc_pkg::ADDR_PERIOD: s_next.rd_data = s_reg.period;
               grfbc_pkg::ADDR_TAP:    s_next.rd_data = s_reg.tap_exp;
               grfbc_pkg::ADDR_DEC:    s_next.rd_data = s_reg.dec_exp;
               grfbc_pkg::ADDR_COARSE: s_next.rd_data = s_reg.coarse;
               grfbc_pkg::ADDR_FINE:   s_next.rd_data = s_reg.fine;
               grfbc_pkg::ADDR_CMD:    s_next.rd_data = {14'h0000, s_reg.cmd_restore, s_reg.cmd_null};
               default:                s_next.rd_data = 16'h0000;
            endcase
         end
      end

      // filter sequencer, one pass per sample
      unique case (s_reg.fsm)
         grfbc_pkg::ST_IDLE: begin
            if (tick) begin
               s_next.sample = raw_rate_i;
               s_next.fsm    = grfbc_pkg::ST_STG1;
               if (b_new != s_reg.act_b) begin
                  s_next.act_b = b_new;
                  s_next.fill1 = '0;
                  s_next.fill2 = '0;
                  s_next.sum1  = '0;
                  s_next.sum2  = '0;
               end
               if (d_new != s_reg.act_d) begin
                  s_next.act_d   = d_new;
                  s_next.dec_cnt = 17'h00000;
                  s_next.acc     = '0;
               end
            end
         end
         grfbc_pkg::ST_STG1: begin
            // oldest tap counts as zero until the window has filled
            old_v = (s_reg.fill1 >= taps) ? SUM_W'($signed(rd1)) : '0;
            sum_v = $signed(s_reg.sum1) + SUM_W'($signed(s_reg.sample)) - old_v;
            s_next.sum1 = sum_v;
            s_next.avg1 = 32'(sum_v >>> s_reg.act_b);
            wr1 = 1'b1;
            if (s_reg.fill1 < (AW + 1)'(DEPTH)) begin
               s_next.fill1 = s_reg.fill1 + (AW + 1)'(1);
            end
            s_next.fsm = grfbc_pkg::ST_STG2;
         end
         grfbc_pkg::ST_STG2: begin
            old_v = (s_reg.fill2 >= taps) ? SUM_W'($signed(rd2)) : '0;
            sum_v = $signed(s_reg.sum2) + SUM_W'($signed(s_reg.avg1)) - old_v;
            s_next.sum2   = sum_v;
            s_next.sample = 32'(sum_v >>> s_reg.act_b);
            wr2 = 1'b1;
            s_next.wp = s_reg.wp + AW'(1);
            if (s_reg.fill2 < (AW + 1)'(DEPTH)) begin
               s_next.fill2 = s_reg.fill2 + (AW + 1)'(1);
            end
            s_next.fsm = grfbc_pkg::ST_DEC;
         end
         grfbc_pkg::ST_DEC: begin
            acc_v = $signed(s_reg.acc) + ACC_W'($signed(s_reg.sample));
            if (s_reg.dec_cnt + 17'h00001 == (17'h00001 << s_reg.act_d)) begin
               unc            = 32'(acc_v >>> s_reg.act_d);
               s_next.rate    = unc + {s_reg.coarse, s_reg.fine};
               s_next.ready   = 1'b1;
               s_next.acc     = '0;
               s_next.dec_cnt = 17'h00000;
               out_evt        = 1'b1;
            end else begin
               s_next.acc     = acc_v;
               s_next.dec_cnt = s_reg.dec_cnt + 17'h00001;
            end
            s_next.fsm = grfbc_pkg::ST_IDLE;
         end
      endcase

      // nulling: skip the cycle in progress, take the next full one
      if (out_evt && s_reg.null_ph == grfbc_pkg::NL_ALIGN) begin
         s_next.null_ph = grfbc_pkg::NL_TAKE;
      end
      if (out_evt && s_reg.null_ph == grfbc_pkg::NL_TAKE) begin
         {s_next.coarse, s_next.fine} = -unc;
         s_next.nvm_upd = 1'b1;
         s_next.null_ph = grfbc_pkg::NL_STORE;
      end
      if (s_reg.null_ph == grfbc_pkg::NL_STORE && nvm_done_i) begin
         s_next.cmd_null = 1'b0;
         s_next.null_ph  = grfbc_pkg::NL_OFF;
      end

      // factory restore, bounded by the memory update limit
      if (restore_go) begin
         s_next.coarse      = grfbc_pkg::OFFSET_RST;
         s_next.fine        = grfbc_pkg::OFFSET_RST;
         s_next.fill1       = '0;
         s_next.fill2       = '0;
         s_next.sum1        = '0;
         s_next.sum2        = '0;
         s_next.acc         = '0;
         s_next.dec_cnt     = 17'h00000;
         s_next.rate        = 32'h0000_0000;
         s_next.ready       = 1'b0;
         s_next.fsm         = grfbc_pkg::ST_IDLE;
         s_next.cmd_restore = 1'b1;
         s_next.nvm_upd     = 1'b1;
         s_next.nvm_cnt     = NVM_W'(RESTORE_CYC);
      end else if (s_reg.cmd_restore) begin
         if (nvm_done_i || s_reg.nvm_cnt == '0) begin
            s_next.cmd_restore = 1'b0;
         end else begin
            s_next.nvm_cnt = s_reg.nvm_cnt - NVM_W'(1);
         end
      end
   end

   // state register
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         s_reg         <= '0;
         s_reg.period  <= grfbc_pkg::PERIOD_RST;
         s_reg.tap_exp <= grfbc_pkg::TAP_RST;
         s_reg.dec_exp <= grfbc_pkg::DEC_RST;
         s_reg.coarse  <= grfbc_pkg::OFFSET_RST;
         s_reg.fine    <= grfbc_pkg::OFFSET_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rd_data_o               = s_reg.rd_data;
   assign rd_valid_o              = s_reg.rd_valid;
   assign primary_rate_output_o   = s_reg.rate[31:16];
   assign secondary_rate_output_o = s_reg.rate[15:0];
   assign data_ready_o            = s_reg.ready;
   assign nvm_update_o            = s_reg.nvm_upd;

   // checks
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   sequence null_cmd_s;
      cmd_valid_i && !s_reg.cmd_null && cmd_word_i == {1'b1, grfbc_pkg::ADDR_CMD, 8'h01};
   endsequence
   sequence null_take_s;
      s_reg.null_ph == grfbc_pkg::NL_TAKE && out_evt;
   endsequence

   null_start_a: assert property (null_cmd_s |=> s_reg.cmd_null ##0
      s_reg.null_ph == grfbc_pkg::NL_ALIGN) else $error("nulling did not start");
   null_store_a: assert property (null_take_s |=> ({s_reg.coarse, s_reg.fine} == -$past(unc))
      && s_reg.nvm_upd) else $error("nulling stored wrong offset");
   null_mute_a: assert property (cmd_valid_i && s_reg.cmd_null |=> !s_reg.rd_valid
      && $stable(s_reg.period)) else $error("port active while nulling");
   null_hold_a: assert property (s_reg.cmd_null && !(s_reg.null_ph == grfbc_pkg::NL_STORE
      && nvm_done_i) |=> s_reg.cmd_null) else $error("nulling aborted");
   restore_clear_a: assert property (restore_go |=> s_reg.coarse == 16'h0000 && s_reg.fine == 16'h0000
      && s_reg.rate == 32'h0000_0000 && s_reg.nvm_upd) else $error("restore left data");
   cmd_selfclear_a: assert property (s_reg.cmd_restore && nvm_done_i && !restore_go
      |=> !s_reg.cmd_restore) else $error("command bit stuck");
   period_floor_a: assert property (int_tick |=> s_reg.per_cnt >= grfbc_pkg::PERIOD_MIN)
      else $error("sample rate above limit");
   ext_hold_a: assert property (s_reg.period == 16'h0000 |=> $stable(s_reg.base_cnt))
      else $error("internal clock ran in external mode");
   apply_bound_a: assert property (!(s_reg.fsm == grfbc_pkg::ST_IDLE && tick) |=> $stable(s_reg.act_b)
      && $stable(s_reg.act_d)) else $error("settings applied mid-sample");
endmodule : grfbc_top
`default_nettype wire

// file: verification/grfbc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module grfbc_host_model (
   // clock and reset
   input  wire logic clock_i,
   input  wire logic rst_b_i,
   // memory handshake
   input  wire logic nvm_update_i,
   input  wire logic slow_i,
   output logic      nvm_done_o,
   // external sample clock
   input  wire logic run_i,
   output logic      ext_clk_o
);
   int cnt;
   // store completes some cycles after each request, slower on demand
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt        <= 0;
         nvm_done_o <= 1'b0;
      end else begin
         nvm_done_o <= (cnt == 1);
         if (nvm_update_i)
            cnt <= slow_i ? 40 : 10;
         else if (cnt != 0)
            cnt <= cnt - 1;
      end
   end
   // link clock, 32 ns period, stands low outside bursts
   initial begin
      ext_clk_o = 1'b0;
      #5;
      forever begin
         #16;
         ext_clk_o = run_i ? ~ext_clk_o : 1'b0;
      end
   end
endmodule : grfbc_host_model
`default_nettype wire

// file: verification/gyro_rate_filter_bias_cal_bench.sv
`timescale 1ns/1ps
`default_nettype none
module gyro_rate_filter_bias_cal_bench;
   logic        clock_i = 1'b0, rst_b_i = 1'b1, cmd_valid = 1'b0, ext_run = 1'b0, slow = 1'b0;
   logic        ext_clk, rd_valid, data_ready, nvm_update, nvm_done;
   logic [15:0] cmd_word = 16'h0000, rd_data, prim, sec;
   logic [31:0] raw = 32'h0000_0000, ofs;
   int          num_errors = 0, check_count = 0, seed = 32'h30a1;
   int          n_ready = 0, cyc = 0, last = 0, span = 0, n0;
   logic [15:0] rd_q[$];
   logic [31:0] out_q[$];
   // 250 MHz clock
   always #2 clock_i = ~clock_i;
   grfbc_top #(.BASE_DIV(4), .RESTORE_CYC(50)) u_dut (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .external_clock_input_pin_i(ext_clk),
      .cmd_valid_i(cmd_valid), .cmd_word_i(cmd_word), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
      .raw_rate_i(raw), .primary_rate_output_o(prim), .secondary_rate_output_o(sec),
      .data_ready_o(data_ready), .nvm_update_o(nvm_update), .nvm_done_i(nvm_done));
   grfbc_host_model u_host (.clock_i(clock_i), .rst_b_i(rst_b_i), .nvm_update_i(nvm_update),
      .slow_i(slow), .nvm_done_o(nvm_done), .run_i(ext_run), .ext_clk_o(ext_clk));
   task automatic fail(input string msg);
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
   endtask : fail
   // one command word, one cycle
   task automatic put(input logic [15:0] w);
      @(negedge clock_i);
      cmd_valid = 1'b1;
      cmd_word  = w;
      @(negedge clock_i);
      cmd_valid = 1'b0;
   endtask : put
   // word write as two byte writes, high byte first
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      put({1'b1, a + 7'h01, d[15:8]});
      put({1'b1, a, d[7:0]});
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [15:0] e);
      rd_q.push_back(e);
      put({1'b0, a, 8'h00});
   endtask : rd
   // spacing of outputs in cycles
   task automatic pace(input int e);
      repeat (3) @(posedge data_ready);
      @(negedge clock_i);
      check_count++;
      if (span != e)
         fail("output spacing");
   endtask : pace
   task automatic conclude;
      if (rd_q.size() != 0)
         fail("read never answered");
      if (out_q.size() != 0)
         fail("output never seen");
      $display("errors %0d, checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude
   // compares answers and outputs against the oldest notes
   always @(posedge clock_i) begin
      if (rd_valid === 1'b1) begin
         check_count++;
         if (rd_q.size() == 0)
            fail("unexpected read answer");
         else if (rd_data !== rd_q.pop_front())
            fail("read data");
      end
      if (data_ready === 1'b1) begin
         n_ready++;
         span = cyc - last;
         last = cyc;
         if (out_q.size() != 0) begin
            check_count++;
            if ({prim, sec} !== out_q.pop_front())
               fail("rate output");
         end
      end
      cyc++;
   end
   // watchdog
   initial begin
      #200000;
      fail("timeout");
      conclude();
   end
   initial begin
      // a real falling edge, so every asynchronous flop is cleared
      #1 rst_b_i = 1'b0;
      repeat (6) @(posedge clock_i);
      @(negedge clock_i);
      rst_b_i = 1'b1;
      // reset values and an unmapped read
      rd(grfbc_pkg::ADDR_FINE, 16'h0000);
      rd(grfbc_pkg::ADDR_COARSE, 16'h0000);
      rd(grfbc_pkg::ADDR_PERIOD, 16'h001F);
      rd(grfbc_pkg::ADDR_TAP, 16'h0000);
      rd(grfbc_pkg::ADDR_DEC, 16'h0000);
      rd(7'h30, 16'h0000);
      pace(128);
      wr(grfbc_pkg::ADDR_PERIOD, 16'h000F);
      pace(64);
      // offsets summed into a filtered, decimated constant input
      raw = $random(seed);
      ofs = $random(seed);
      wr(grfbc_pkg::ADDR_FINE, ofs[15:0]);
      wr(grfbc_pkg::ADDR_COARSE, ofs[31:16]);
      wr(grfbc_pkg::ADDR_TAP, 16'h0002);
      wr(grfbc_pkg::ADDR_DEC, 16'h0002);
      rd(grfbc_pkg::ADDR_COARSE, ofs[31:16]);
      rd(grfbc_pkg::ADDR_FINE, ofs[15:0]);
      pace(256);
      out_q.push_back(raw + ofs);
      repeat (2) @(posedge data_ready);
      // restore clears offsets, busy bit until memory done
      put(16'hA802);
      rd(grfbc_pkg::ADDR_CMD, 16'h0002);
      rd(grfbc_pkg::ADDR_FINE, 16'h0000);
      rd(grfbc_pkg::ADDR_COARSE, 16'h0000);
      repeat (60) @(posedge clock_i);
      rd(grfbc_pkg::ADDR_CMD, 16'h0000);
      wr(grfbc_pkg::ADDR_TAP, 16'h0000);
      wr(grfbc_pkg::ADDR_DEC, 16'h0000);
      // external sample clock
      wr(grfbc_pkg::ADDR_PERIOD, 16'h0000);
      repeat (20) @(posedge clock_i);
      n0 = n_ready;
      repeat (300) @(posedge clock_i);
      check_count++;
      if (n_ready != n0)
         fail("internal clock not stopped");
      ext_run = 1'b1;
      repeat (10) @(posedge ext_clk);
      ext_run = 1'b0;
      repeat (20) @(posedge clock_i);
      check_count++;
      if (n_ready - n0 != 10)
         fail("external sample count");
      wr(grfbc_pkg::ADDR_PERIOD, 16'h000F);
      // nulling: port ignored, not abortable, offsets take minus output
      slow = 1'b1;
      raw  = $random(seed); // held still while nulling
      ofs  = -raw;
      repeat (200) @(posedge clock_i);
      put(16'hA801);
      put(16'h1E00);
      put(16'hA802);
      @(posedge nvm_update);
      repeat (60) @(posedge clock_i);
      rd(grfbc_pkg::ADDR_FINE, ofs[15:0]);
      rd(grfbc_pkg::ADDR_COARSE, ofs[31:16]);
      rd(grfbc_pkg::ADDR_CMD, 16'h0000);
      out_q.push_back(32'h0000_0000);
      repeat (2) @(posedge data_ready);
      // hardware reset is the one way to cut a running nulling short
      put(16'hA801);
      repeat (10) @(posedge clock_i);
      @(negedge clock_i);
      rst_b_i = 1'b0;
      repeat (2) @(negedge clock_i);
      rst_b_i = 1'b1;
      rd(grfbc_pkg::ADDR_CMD, 16'h0000);
      rd(grfbc_pkg::ADDR_PERIOD, 16'h001F);
      repeat (4) @(posedge clock_i);
      conclude();
   end
endmodule : gyro_rate_filter_bias_cal_bench
`default_nettype wire
